// ### src/cbo_regs.sv
// Command register and bus access control register with command sequencer handshake.
`timescale 1ns/1ps
`include "cbo_cfg.svh"
// Contract
// [R1] Standby bit powers down whole chip.
// [R2] Bit 6 powers down receiver and transmitter.
// [R3] Low five bits are command code.
// [R4] Sequencer clears command field when finished.
// [R5] Unlock bit permits next access change.
// [R6] Next write clears the unlock bit.
// [R7] Bit 6 grants bus to host.
// [R8] Bit 5 grants bus to secure module.
// [R9] Both owner bits never set together.
// [R10] Owner bits set only after unlock.
// [R11] Bits 3..2 select secure module link.
// [R12] Host preserves reserved bits by read-modify-write.
// [R13] Both-owner write keeps old owners, consumes unlock.
module cbo_regs
(
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     rst,
	// Host register port.
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [`CBO_ADDR_W-1:0]   reg_addr,
	input  wire logic [7:0]               reg_wdata,
	output logic      [7:0]               reg_rdata,
	// Command sequencer.
	output logic                          cmd_start,
	output logic      [4:0]               cmd_code,
	input  wire logic                     cmd_done,
	// Power and bus control.
	output logic                          chip_power_down,
	output logic                          rf_frontend_power_off,
	output logic                          owner_is_main_controller,
	output logic                          owner_is_secure_module,
	output cbo_pkg::cbo_link_t            secure_module_link_select
);
	logic [7:0]        cmd_q;
	logic              unlock_q;
	logic              host_q;
	logic              sam_q;
	logic [1:0]        link_q;
	logic              start_q;
	logic [7:0]        rdata_q;
	cbo_pkg::cbo_seq_t seq_q;
	logic              wr_cmd;
	logic              wr_bac;
	logic              rd_any;

	assign wr_cmd = reg_wr && (reg_addr == `CBO_OFS_CMD);
	assign wr_bac = reg_wr && (reg_addr == `CBO_OFS_BAC);
	assign rd_any = reg_rd;

	// Tells whether a command code asks the sequencer to run.
	function automatic logic code_is_live(input logic [4:0] code);
		return code != `CBO_CODE_IDLE;
	endfunction

	// Command register; a finished command returns the field to idle.
	always_ff @(posedge clk)
	begin
		if (rst)
			cmd_q <= `CBO_CMD_RESET;
		else if (wr_cmd)
			cmd_q <= {reg_wdata[7:6], 1'b0, reg_wdata[`CBO_CMD_CODE_MSB:0]}; // [R3]
		else if (cmd_done && seq_q == cbo_pkg::CBO_BUSY)
			cmd_q[`CBO_CMD_CODE_MSB:0] <= `CBO_CODE_IDLE; // [R4]
	end

	// Sequencer handshake: a non-idle code launches one start pulse.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			seq_q   <= cbo_pkg::CBO_IDLE;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= wr_cmd && code_is_live(reg_wdata[`CBO_CMD_CODE_MSB:0]);
			case (seq_q)
				cbo_pkg::CBO_IDLE:
					if (wr_cmd && code_is_live(reg_wdata[`CBO_CMD_CODE_MSB:0]))
						seq_q <= cbo_pkg::CBO_BUSY;
				cbo_pkg::CBO_BUSY:
					// A new live command replaces the running one and stays busy.
					if (wr_cmd && code_is_live(reg_wdata[`CBO_CMD_CODE_MSB:0]))
						seq_q <= cbo_pkg::CBO_BUSY;
					else if (cmd_done || wr_cmd)
						seq_q <= cbo_pkg::CBO_IDLE; // [R4]
				default:
					seq_q <= cbo_pkg::CBO_IDLE;
			endcase
		end
	end

	// Bus access control; the unlock is one-shot.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			unlock_q <= 1'(`CBO_BAC_RESET >> `CBO_BAC_UNLOCK_BIT);
			host_q   <= 1'b0;
			sam_q    <= 1'b0;
			link_q   <= 2'h0;
		end
		else if (wr_bac)
		begin
			if (unlock_q) // [R5]
			begin
				unlock_q <= 1'b0; // [R6]
				link_q   <= reg_wdata[`CBO_BAC_LINK_MSB:`CBO_BAC_LINK_LSB]; // [R11]
				if (!(reg_wdata[`CBO_BAC_HOST_BIT] && reg_wdata[`CBO_BAC_SAM_BIT])) // [R9] [R13]
				begin
					host_q <= reg_wdata[`CBO_BAC_HOST_BIT]; // [R7]
					sam_q  <= reg_wdata[`CBO_BAC_SAM_BIT]; // [R8]
				end
			end
			else
			begin
				unlock_q <= reg_wdata[`CBO_BAC_UNLOCK_BIT];
				// Without unlock owners may only be dropped, never raised.
				host_q   <= host_q & reg_wdata[`CBO_BAC_HOST_BIT]; // [R10]
				sam_q    <= sam_q & reg_wdata[`CBO_BAC_SAM_BIT]; // [R10]
				link_q   <= reg_wdata[`CBO_BAC_LINK_MSB:`CBO_BAC_LINK_LSB]; // [R11]
			end
		end
	end

	// Read data register.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_q <= 8'h00;
		else if (rd_any)
			case (reg_addr)
				`CBO_OFS_CMD: rdata_q <= cmd_q;
				`CBO_OFS_BAC: rdata_q <= {unlock_q, host_q, sam_q, 1'b0, link_q, 2'b00};
				default:      rdata_q <= 8'h00;
			endcase
	end

	assign reg_rdata                 = rdata_q;
	assign cmd_start                 = start_q;
	assign cmd_code                  = cmd_q[`CBO_CMD_CODE_MSB:0]; // [R3]
	assign chip_power_down           = cmd_q[`CBO_CMD_STANDBY_BIT]; // [R1]
	assign rf_frontend_power_off     = cmd_q[`CBO_CMD_RFOFF_BIT]; // [R2]
	assign owner_is_main_controller  = host_q; // [R7]
	assign owner_is_secure_module    = sam_q; // [R8]
	assign secure_module_link_select = cbo_pkg::cbo_link_t'(link_q); // [R11]

	owners_exclusive_a: assert property (@(posedge clk) disable iff (rst) // [R9]
		!(host_q && sam_q))
		else $error("Both bus owners set.");

	sequence unlock_armed_s;
		!unlock_q ##0 (wr_bac && reg_wdata[`CBO_BAC_UNLOCK_BIT]);
	endsequence

	unlock_then_clear_a: assert property (@(posedge clk) disable iff (rst) // [R6]
		unlock_q && wr_bac |=> !unlock_q)
		else $error("Unlock not cleared by write.");

	unlock_arm_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		unlock_armed_s |=> unlock_q)
		else $error("Unlock bit not armed.");

	owner_locked_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		!unlock_q && !host_q |=> !host_q)
		else $error("Host owner raised without unlock.");

	sam_locked_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		!unlock_q && !sam_q |=> !sam_q)
		else $error("Module owner raised without unlock.");

	both_keep_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		unlock_q && wr_bac && reg_wdata[6] && reg_wdata[5]
		|=> $stable(host_q) && $stable(sam_q) && !unlock_q)
		else $error("Both-owner write changed owners.");

	host_grant_a: assert property (@(posedge clk) disable iff (rst) // [R7]
		unlock_q && wr_bac && reg_wdata[6] && !reg_wdata[5] |=> owner_is_main_controller)
		else $error("Host grant missing.");

	done_clears_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		seq_q == cbo_pkg::CBO_BUSY && cmd_done && !wr_cmd |=> cmd_code == 5'h00)
		else $error("Command field not cleared at done.");

	cmd_write_a: assert property (@(posedge clk) disable iff (rst) // [R1]
		wr_cmd |=> chip_power_down == $past(reg_wdata[7])
			&& rf_frontend_power_off == $past(reg_wdata[6]))
		else $error("Power bits not taken from write.");

	rf_off_take_a: assert property (@(posedge clk) disable iff (rst) // [R2]
		wr_cmd |=> rf_frontend_power_off == $past(reg_wdata[`CBO_CMD_RFOFF_BIT]))
		else $error("Front end power bit not taken from write.");

	code_take_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		wr_cmd |=> cmd_code == $past(reg_wdata[`CBO_CMD_CODE_MSB:0]))
		else $error("Command code not taken from write.");

	reserved_clear_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		reg_rd && reg_addr == `CBO_OFS_CMD |=> !reg_rdata[5])
		else $error("Reserved command bit read as one.");

	start_pulse_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		wr_cmd && reg_wdata[4:0] != 5'h00 |=> cmd_start)
		else $error("Start pulse missing.");

	start_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		!wr_cmd |=> !cmd_start)
		else $error("Start pulse without command write.");

	sequence cmd_launch_s;
		(wr_cmd && reg_wdata[4:0] != 5'h00) ##1 cmd_start;
	endsequence

	launch_busy_a: assert property (@(posedge clk) disable iff (rst) // [R4]
		cmd_launch_s |-> seq_q == cbo_pkg::CBO_BUSY)
		else $error("Sequencer not busy after start.");

	sam_grant_a: assert property (@(posedge clk) disable iff (rst) // [R8]
		unlock_q && wr_bac && reg_wdata[5] && !reg_wdata[6] |=> owner_is_secure_module)
		else $error("Module grant missing.");

	owner_rise_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		$rose(host_q) || $rose(sam_q) |-> $past(unlock_q))
		else $error("Owner raised without prior unlock.");

	link_take_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		wr_bac |=> secure_module_link_select == $past(reg_wdata[3:2]))
		else $error("Link select not taken from write.");
endmodule

// ### src/cbo_cfg.svh
// Register offsets, field positions and reset values of the command and bus owner registers.
`ifndef CBO_CFG_SVH
`define CBO_CFG_SVH
`define CBO_ADDR_W           7
`define CBO_OFS_CMD          7'h00
`define CBO_OFS_BAC          7'h01
`define CBO_CMD_STANDBY_BIT  7
`define CBO_CMD_RFOFF_BIT    6
`define CBO_CMD_CODE_MSB     4
`define CBO_BAC_UNLOCK_BIT   7
`define CBO_BAC_HOST_BIT     6
`define CBO_BAC_SAM_BIT      5
`define CBO_BAC_LINK_MSB     3
`define CBO_BAC_LINK_LSB     2
`define CBO_CMD_RESET        8'h00
`define CBO_BAC_RESET        8'h00
`define CBO_CODE_IDLE        5'h00
`endif

// ### src/cbo_pkg.sv
// Types shared by the command and bus owner register block.
package cbo_pkg;
	typedef enum logic [1:0] {
		CBO_LINK_OFF  = 2'h0,
		CBO_LINK_SPI  = 2'h1,
		CBO_LINK_I2CL = 2'h2,
		CBO_LINK_I2C  = 2'h3
	} cbo_link_t;
	typedef enum {
		CBO_IDLE,
		CBO_BUSY
	} cbo_seq_t;
endpackage

// ### tb/cbo_seq_model.sv
// Behavioural command sequencer that answers a start with a done pulse; a start while counting restarts the count.
`timescale 1ns/1ps
module cbo_seq_model
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Sequencer handshake.
	input  wire logic cmd_start,
	output logic      cmd_done
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk)
	begin
		cnt_q <= rst ? 4'h0 : (cmd_start ? 4'h3 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0));
		cmd_done <= !rst && cnt_q == 4'h1;
	end
endmodule

// ### tb/cbo_regs_test.sv
// Self-checking bench of the command and bus owner registers.
`timescale 1ns/1ps
module cbo_regs_test;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [6:0]         reg_addr = 7'h00;
	logic [7:0]         reg_wdata = 8'h00;
	logic [7:0]         reg_rdata;
	logic [4:0]         cmd_code;
	logic               cmd_start, cmd_done, chip_power_down, rf_frontend_power_off;
	logic               owner_is_main_controller, owner_is_secure_module;
	cbo_pkg::cbo_link_t secure_module_link_select;
	int                 miscompares = 0;
	int                 total_checks = 0;
	int                 start_pulses = 0;
	cbo_regs cbo_regs_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_done(cmd_done),
		.chip_power_down(chip_power_down), .rf_frontend_power_off(rf_frontend_power_off),
		.owner_is_main_controller(owner_is_main_controller),
		.owner_is_secure_module(owner_is_secure_module),
		.secure_module_link_select(secure_module_link_select));
	cbo_seq_model cbo_seq_model_inst (.clk(clk), .rst(rst), .cmd_start(cmd_start),
		.cmd_done(cmd_done));
	always @(negedge clk)
	begin
		if (cmd_start === 1'b1)
			start_pulses++;
	end
	initial
	begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
		@(negedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#20000;
		miscompares++;
		end_of_test();
	end
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		rd(7'h00, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(7'h01, 8'h40 | 8'(k << 2));
			chk({6'h00, secure_module_link_select}, 8'(k));
			chk({7'h00, owner_is_main_controller}, 8'h00);
		end
		$display("test 1 done");
		wr(7'h01, 8'h80);
		wr(7'h01, 8'h44);
		rd(7'h01, 8'h44);
		chk({7'h00, owner_is_main_controller}, 8'h01);
		wr(7'h01, 8'hC4);
		wr(7'h01, 8'h64);
		rd(7'h01, 8'h44);
		wr(7'h01, 8'h20);
		rd(7'h01, 8'h00);
		wr(7'h01, 8'h80);
		wr(7'h01, 8'h28);
		rd(7'h01, 8'h28);
		chk({owner_is_main_controller, owner_is_secure_module}, 8'h01);
		$display("test 2 done");
		wr(7'h00, 8'hE5);
		chk({chip_power_down, rf_frontend_power_off, 1'b0, cmd_code}, 8'hC5);
		rd(7'h00, 8'hC5);
		repeat (8) @(negedge clk);
		rd(7'h00, 8'hC0);
		chk({3'h0, cmd_code}, 8'h00);
		wr(7'h00, 8'h40);
		chk({chip_power_down, rf_frontend_power_off}, 8'h01);
		wr(7'h00, 8'h00);
		chk({chip_power_down, rf_frontend_power_off}, 8'h00);
		chk(8'(start_pulses), 8'h01);
		wr(7'h7F, 8'h55);
		rd(7'h7F, 8'h00);
		$display("test 3 done");
		end_of_test();
	end
endmodule
